// ---- rtl/cps_pkg.sv ----
// constants, types and decode helpers for converter power-state control
`default_nettype none
package cps_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CLKS_OFS = 8'h04;
  localparam logic [7:0] SAMP_OFS = 8'h08;
  localparam logic [7:0] CNTS_OFS = 8'h0c;
  localparam logic [7:0] TRIM_OFS = 8'h10;
  localparam logic [7:0] STAT_OFS = 8'h14;
  localparam logic [7:0] FLAG_OFS = 8'h18;
  localparam logic [7:0] CALV_OFS = 8'h1c;
  // ----------------------------------------------------------------
  // control word fields and reset value
  // ----------------------------------------------------------------
  localparam int CTRL_RESETB = 0;
  localparam int CTRL_BIAS   = 1;
  localparam int CTRL_ADCEN  = 2;
  localparam int CTRL_SKIP   = 3;
  localparam int CTRL_EXTREF = 4;
  localparam int CTRL_REFSEL = 5;
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam int FLAG_READY  = 0;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ      = 20_000_000;
  localparam int CAL_TIME_MS = 100;
  localparam int CAL_CYCLES  = CLK_HZ / 1000 * CAL_TIME_MS;
  localparam logic [8:0] TRACK_BASE = 9'h004;
  localparam logic [8:0] TRACK_MIN  = 9'h008;
  localparam logic [8:0] HOLD_BASE  = 9'h011;
  localparam logic [3:0] DIV_MAX    = 4'h3;
  // ----------------------------------------------------------------
  // states and reference choices
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_RESET = 5'b00001,
    ST_SLEEP = 5'b00010,
    ST_NAP   = 5'b00100,
    ST_CAL   = 5'b01000,
    ST_ON    = 5'b10000
  } cps_state_t;
  localparam logic [1:0] REF_INT_125 = 2'h0;
  localparam logic [1:0] REF_INT_204 = 2'h1;
  localparam logic [1:0] REF_EXT     = 2'h2;

  function automatic logic [12:0] cps_bias_cycles(input logic [3:0] s);
    if (s <= 4'h8) return 13'(13'h004 << s);
    else if (s <= 4'hd) return 13'(13'h200 * 13'(s - 4'h6));
    else if (s == 4'he) return 13'hffe;
    else return 13'h1200;
  endfunction

  function automatic logic [5:0] cps_wake_cycles(input logic [3:0] s);
    if (s[3]) return 6'(({2'h0, s} - 6'h03) << 2);
    else return 6'(({2'h0, s} + 6'h01) << 1);
  endfunction

  function automatic logic [1:0] cps_ref_mode(input logic ext,
                                              input logic sel);
    if (ext) return REF_EXT;
    else if (sel) return REF_INT_204;
    else return REF_INT_125;
  endfunction
endpackage
`default_nettype wire

// ---- rtl/cps_tim_if.sv ----
// carrier between the state controller and its timing generator
`timescale 1ns/1ps
`default_nettype none
interface cps_tim_if;
  logic [3:0] clkdiv;
  logic [7:0] track_cnt;
  logic [7:0] idle_cnt;
  logic [3:0] bias_set;
  logic [3:0] wake_set;
  logic       run;
  logic       wake_go;
  logic       bit_en;
  logic       sample_clk;
  logic       bias_done;
  logic       wake_done;
  modport ctl (output clkdiv, track_cnt, idle_cnt, bias_set, wake_set,
               run, wake_go,
               input  bit_en, sample_clk, bias_done, wake_done);
  modport tim (input  clkdiv, track_cnt, idle_cnt, bias_set, wake_set,
               run, wake_go,
               output bit_en, sample_clk, bias_done, wake_done);
endinterface
`default_nettype wire

// ---- rtl/cps_timing.sv ----
// bit clock divider, sample clock and warm-up counters
`timescale 1ns/1ps
`default_nettype none
module cps_timing (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link to controller
  cps_tim_if.tim   t
);
  logic [3:0] div_reg;
  logic [8:0] ph_reg;
  logic       sclk_reg;
  logic       srise;
  logic [12:0] bcnt_reg;
  logic [5:0] wcnt_reg;
  logic       bdone_reg;
  logic       wdone_reg;
  logic [3:0] div_lim;
  logic [8:0] ph_lim;
  logic [8:0] track_len;

  // ----------------------------------------------------------------
  // bit clock enable
  // ----------------------------------------------------------------
  assign div_lim  = 4'((5'h02 << t.clkdiv[1:0]) - 5'h01);
  assign t.bit_en = t.run & ((t.clkdiv > cps_pkg::DIV_MAX) |
                             (div_reg == div_lim)); // R21

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div_reg <= 4'h0;
    else if (!t.run || t.bit_en) div_reg <= 4'h0;
    else div_reg <= div_reg + 4'h1;
  end

  // ----------------------------------------------------------------
  // sample clock
  // ----------------------------------------------------------------
  // track is clamped so a tiny count cannot starve the sampler
  assign track_len = (cps_pkg::TRACK_BASE + 9'(t.track_cnt) <
                      cps_pkg::TRACK_MIN) ? cps_pkg::TRACK_MIN :
                     cps_pkg::TRACK_BASE + 9'(t.track_cnt);
  assign ph_lim = sclk_reg ? track_len - 9'h001 :
                  cps_pkg::HOLD_BASE + 9'(t.idle_cnt) - 9'h001; // R20
  assign srise  = t.bit_en & !sclk_reg & (ph_reg == ph_lim);
  assign t.sample_clk = sclk_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_reg   <= 9'h000;
      sclk_reg <= 1'b0;
    end else if (!t.run) begin
      ph_reg   <= 9'h000;
      sclk_reg <= 1'b0;
    end else if (t.bit_en) begin
      if (ph_reg == ph_lim) begin
        ph_reg   <= 9'h000;
        sclk_reg <= !sclk_reg; // R20
      end else begin
        ph_reg <= ph_reg + 9'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // bias and wake-up counters, stepped by the sample clock
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcnt_reg  <= 13'h0000;
      bdone_reg <= 1'b0;
    end else if (!t.run) begin
      bcnt_reg  <= 13'h0000;
      bdone_reg <= 1'b0;
    end else if (srise && !bdone_reg) begin
      bcnt_reg  <= bcnt_reg + 13'h0001; // R22
      bdone_reg <= (bcnt_reg + 13'h0001 ==
                    cps_pkg::cps_bias_cycles(t.bias_set)); // R17
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wcnt_reg  <= 6'h00;
      wdone_reg <= 1'b0;
    end else if (!t.run || t.wake_go) begin
      wcnt_reg  <= 6'h00;
      wdone_reg <= 1'b0;
    end else if (srise && !wdone_reg) begin
      wcnt_reg  <= wcnt_reg + 6'h01; // R22
      wdone_reg <= (wcnt_reg + 6'h01 ==
                    cps_pkg::cps_wake_cycles(t.wake_set)); // R18
    end
  end

  assign t.bias_done = bdone_reg;
  assign t.wake_done = wdone_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  div_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
    t.run && t.clkdiv > cps_pkg::DIV_MAX |-> t.bit_en) // R21
    else $error("bit clock not passed through");
  div_half_a: assert property (@(posedge pclk) disable iff (!presetn)
    t.run && t.clkdiv == 4'h0 && t.bit_en |=> !t.bit_en) // R21
    else $error("divide by two broken");
  bias_count_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(bdone_reg) |-> bcnt_reg ==
      cps_pkg::cps_bias_cycles(t.bias_set)) // R17
    else $error("bias count wrong at expiry");
  wake_count_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(wdone_reg) |-> 6'(wcnt_reg) ==
      cps_pkg::cps_wake_cycles(t.wake_set)) // R18
    else $error("wake count wrong at expiry");
endmodule
`default_nettype wire

// ---- rtl/cps_ctrl.sv ----
// converter power-state controller with apb register file
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Operation
// R01: any reset drops bias, clears calibration
// R02: state follows control bits; ready only active
// R03: stay reset while release low; then sleep
// R04: bias enable moves sleep to nap
// R05: software times 500us regulator warm-up
// R06: software sets sample rate in nap
// R07: enable without skip runs 100ms calibration
// R08: active after calibration; ready event, status
// R09: calibration only entered from nap
// R10: calibration kept until reset state
// R11: software initialisation order ends with release
// R12: reference chosen by external and select bits
// R13: software calibrating entry sequence from nap
// R14: software skip entry needs prior calibration
// R15: flag bits clear on write of one
// R16: software picks bias and wake settings
// R17: bias setting decodes to table counts
// R18: wake setting decodes to table counts
// R19: trim pending, applied on calibrating entry
// R20: sample high 4+track, low 17+idle; the code keeps high at least 8 bit clocks
// R21: divider two to setting+1, else bypass
// R22: warm counters on sample clock gate core
// R23: clearing enables falls back, keeps calibration
module cps_ctrl #(
  parameter int CAL_CYCLES = cps_pkg::CAL_CYCLES
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        periph_rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // converter core side
  output var  logic        bias_reg_en,
  output var  logic        core_en,
  output var  logic [1:0]  ref_mode,
  output var  logic        converter_bit_clock,
  output var  logic        sample_clk,
  output var  logic        core_usable,
  output var  logic [7:0]  cal_trim,
  output var  logic        ready
);
  cps_tim_if t ();

  cps_pkg::cps_state_t state_reg;
  cps_pkg::cps_state_t state_next;
  logic [5:0]  ctrl_reg;
  logic [3:0]  clkdiv_reg;
  logic [15:0] samp_reg;
  logic [7:0]  cnts_reg;
  logic [7:0]  trim_reg;
  logic [7:0]  cal_trim_reg;
  logic        flag_reg;
  logic [31:0] cal_cnt_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rdata_next;
  logic        setup;
  logic        wr;
  logic        hit;
  logic        cal_done;
  logic        ready_evt;

  // ----------------------------------------------------------------
  // apb access
  // ----------------------------------------------------------------
  function automatic logic cps_is_wr(input logic [7:0] a,
                                     input logic [7:0] ofs);
    return psel && penable && pwrite && a == ofs;
  endfunction

  assign setup   = psel && !penable;
  assign wr      = psel && penable && pwrite;
  assign hit     = paddr inside {cps_pkg::CTRL_OFS, cps_pkg::CLKS_OFS,
                   cps_pkg::SAMP_OFS, cps_pkg::CNTS_OFS, cps_pkg::TRIM_OFS,
                   cps_pkg::STAT_OFS, cps_pkg::FLAG_OFS, cps_pkg::CALV_OFS};
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata  = prdata_reg;

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg   <= cps_pkg::CTRL_RST;
      clkdiv_reg <= 4'h0;
      samp_reg   <= 16'h0000;
      cnts_reg   <= 8'h00;
    end else if (periph_rst) begin
      ctrl_reg   <= cps_pkg::CTRL_RST; // R01
      clkdiv_reg <= 4'h0;
      samp_reg   <= 16'h0000;
      cnts_reg   <= 8'h00;
    end else begin
      if (cps_is_wr(paddr, cps_pkg::CTRL_OFS)) ctrl_reg <= pwdata[5:0];
      if (cps_is_wr(paddr, cps_pkg::CLKS_OFS)) clkdiv_reg <= pwdata[3:0];
      if (cps_is_wr(paddr, cps_pkg::SAMP_OFS)) samp_reg <= pwdata[15:0];
      if (cps_is_wr(paddr, cps_pkg::CNTS_OFS)) cnts_reg <= pwdata[7:0];
    end
  end

  // pending trim and applied calibration values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_reg     <= 8'h00;
      cal_trim_reg <= 8'h00;
    end else if (periph_rst || state_reg == cps_pkg::ST_RESET) begin
      trim_reg     <= 8'h00; // R01
      cal_trim_reg <= 8'h00; // R10
    end else begin
      if (cps_is_wr(paddr, cps_pkg::TRIM_OFS)) trim_reg <= pwdata[7:0];
      if (state_reg == cps_pkg::ST_CAL && state_next == cps_pkg::ST_ON)
        cal_trim_reg <= trim_reg; // R19
    end
  end

  // ----------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (!ctrl_reg[cps_pkg::CTRL_RESETB]) begin
      state_next = cps_pkg::ST_RESET; // R03
    end else begin
      unique case (state_reg)
        cps_pkg::ST_RESET: state_next = cps_pkg::ST_SLEEP; // R03
        cps_pkg::ST_SLEEP: begin
          if (ctrl_reg[cps_pkg::CTRL_BIAS])
            state_next = cps_pkg::ST_NAP; // R04
        end
        cps_pkg::ST_NAP: begin
          if (!ctrl_reg[cps_pkg::CTRL_BIAS])
            state_next = cps_pkg::ST_SLEEP; // R23
          else if (ctrl_reg[cps_pkg::CTRL_ADCEN])
            state_next = ctrl_reg[cps_pkg::CTRL_SKIP] ?
                         cps_pkg::ST_ON : cps_pkg::ST_CAL; // R07 R09
        end
        cps_pkg::ST_CAL: begin
          if (!ctrl_reg[cps_pkg::CTRL_BIAS])
            state_next = cps_pkg::ST_SLEEP; // R23
          else if (!ctrl_reg[cps_pkg::CTRL_ADCEN])
            state_next = cps_pkg::ST_NAP; // R23
          else if (cal_done)
            state_next = cps_pkg::ST_ON; // R08
        end
        cps_pkg::ST_ON: begin
          if (!ctrl_reg[cps_pkg::CTRL_BIAS])
            state_next = cps_pkg::ST_SLEEP; // R23
          else if (!ctrl_reg[cps_pkg::CTRL_ADCEN])
            state_next = cps_pkg::ST_NAP; // R23
        end
        default: state_next = cps_pkg::ST_RESET;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state_reg <= cps_pkg::ST_RESET;
    else if (periph_rst) state_reg <= cps_pkg::ST_RESET; // R01
    else state_reg <= state_next;
  end

  // calibration run time; restarts on every entry
  assign cal_done = cal_cnt_reg == 32'(CAL_CYCLES - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cal_cnt_reg <= 32'h0;
    else if (state_reg != cps_pkg::ST_CAL) cal_cnt_reg <= 32'h0;
    else cal_cnt_reg <= cal_cnt_reg + 32'h1; // R07
  end

  // ----------------------------------------------------------------
  // ready event flag, set wins over write-one clear
  // ----------------------------------------------------------------
  assign ready_evt = state_next == cps_pkg::ST_ON &&
                     state_reg != cps_pkg::ST_ON && !periph_rst;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) flag_reg <= 1'b0;
    else if (periph_rst) flag_reg <= 1'b0;
    else if (ready_evt) flag_reg <= 1'b1; // R08
    else if (cps_is_wr(paddr, cps_pkg::FLAG_OFS) &&
             pwdata[cps_pkg::FLAG_READY])
      flag_reg <= 1'b0; // R15
  end

  // ----------------------------------------------------------------
  // read data, captured in the setup cycle
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = 32'h0;
    unique case (paddr)
      cps_pkg::CTRL_OFS: rdata_next = {26'h0, ctrl_reg};
      cps_pkg::CLKS_OFS: rdata_next = {28'h0, clkdiv_reg};
      cps_pkg::SAMP_OFS: rdata_next = {16'h0, samp_reg};
      cps_pkg::CNTS_OFS: rdata_next = {24'h0, cnts_reg};
      cps_pkg::TRIM_OFS: rdata_next = {24'h0, trim_reg};
      cps_pkg::STAT_OFS: rdata_next = {23'h0, t.wake_done, t.bias_done,
                                       core_usable, state_reg, ready};
      cps_pkg::FLAG_OFS: rdata_next = {31'h0, flag_reg};
      cps_pkg::CALV_OFS: rdata_next = {24'h0, cal_trim_reg};
      default:           rdata_next = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_reg <= 32'h0;
    else if (setup && !pwrite) prdata_reg <= rdata_next;
  end

  // ----------------------------------------------------------------
  // core outputs and timing generator
  // ----------------------------------------------------------------
  assign ready       = state_reg == cps_pkg::ST_ON; // R02
  assign bias_reg_en = state_reg inside {cps_pkg::ST_NAP, cps_pkg::ST_CAL,
                                         cps_pkg::ST_ON}; // R02 R04
  assign core_en     = state_reg inside {cps_pkg::ST_CAL, cps_pkg::ST_ON};
  assign ref_mode    = cps_pkg::cps_ref_mode(
                         ctrl_reg[cps_pkg::CTRL_EXTREF],
                         ctrl_reg[cps_pkg::CTRL_REFSEL]); // R12
  assign cal_trim    = cal_trim_reg;
  assign core_usable = ready && t.bias_done && t.wake_done; // R22
  assign converter_bit_clock = t.bit_en;
  assign sample_clk  = t.sample_clk;

  assign t.clkdiv    = clkdiv_reg;
  assign t.track_cnt = samp_reg[7:0];
  assign t.idle_cnt  = samp_reg[15:8];
  assign t.bias_set  = cnts_reg[3:0];
  assign t.wake_set  = cnts_reg[7:4];
  assign t.run       = bias_reg_en;
  assign t.wake_go   = state_reg == cps_pkg::ST_NAP &&
                       state_next != cps_pkg::ST_NAP; // R22

  cps_timing cps_timing_i (
    .pclk    (pclk),
    .presetn (presetn),
    .t       (t)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_nap_go(logic skip);
    state_reg == cps_pkg::ST_NAP && !periph_rst &&
    ctrl_reg[cps_pkg::CTRL_RESETB] && ctrl_reg[cps_pkg::CTRL_BIAS] &&
    ctrl_reg[cps_pkg::CTRL_ADCEN] && ctrl_reg[cps_pkg::CTRL_SKIP] == skip;
  endsequence

  ready_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    ready |-> bias_reg_en && core_en &&
      ($past(ctrl_reg) & 6'h07) == 6'h07) // R02
    else $error("ready not tied to active state");
  hold_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_reg[cps_pkg::CTRL_RESETB] |=> state_reg == cps_pkg::ST_RESET &&
      !bias_reg_en) // R03
    else $error("reset state not held");
  sleep_go_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == cps_pkg::ST_SLEEP && ctrl_reg[1:0] == 2'h3 &&
      !periph_rst |=> bias_reg_en && !core_en) // R04
    else $error("sleep to nap failed");
  cal_path_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_nap_go(1'b0) |=> state_reg == cps_pkg::ST_CAL && !ready) // R07
    else $error("calibration not started");
  skip_path_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_nap_go(1'b1) |=> ready && flag_reg) // R08
    else $error("skip path did not reach active");
  cal_from_nap_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state_reg == cps_pkg::ST_CAL) |->
      $past(state_reg) == cps_pkg::ST_NAP) // R09
    else $error("calibration entered from wrong state");
  cal_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == cps_pkg::ST_RESET |=> cal_trim_reg == 8'h00) // R01 R10
    else $error("calibration not cleared in reset");
  trim_apply_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(cal_trim_reg) |-> $past(state_reg) == cps_pkg::ST_CAL ||
      cal_trim_reg == 8'h00) // R19
    else $error("trim applied outside calibrating entry");
  flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    cps_is_wr(paddr, cps_pkg::FLAG_OFS) && pwdata[0] && !ready_evt
      |=> !flag_reg) // R15
    else $error("flag not cleared by write one");
  fall_back_a: assert property (@(posedge pclk) disable iff (!presetn)
    ready && !ctrl_reg[cps_pkg::CTRL_ADCEN] && ctrl_reg[1:0] == 2'h3 &&
      !periph_rst |=> state_reg == cps_pkg::ST_NAP &&
      $stable(cal_trim_reg)) // R23
    else $error("fall back lost calibration");
endmodule
`default_nettype wire

// ---- verification/cps_ctrl_bench.sv ----
// self-checking bench for the converter power-state controller
`timescale 1ns/1ps
`default_nettype none
module cps_ctrl_bench;
  // --------------------
  // signals
  // --------------------
  localparam int CAL = 20;
  // 500 us regulator warm-up in 50 ns cycles
  localparam int WARM = 10000;
  logic        pclk;
  logic        presetn;
  logic        periph_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        bias_reg_en;
  logic        core_en;
  logic [1:0]  ref_mode;
  logic        bit_clk;
  logic        sample_clk;
  logic        core_usable;
  logic [7:0]  cal_trim;
  logic        ready;
  logic        err_seen;
  logic [31:0] q;
  int          n;
  int          mismatches;
  int          checks_done;
  int          cycles;

  cps_ctrl #(.CAL_CYCLES(CAL)) cps_ctrl_i (
    .pclk(pclk), .presetn(presetn), .periph_rst(periph_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bias_reg_en(bias_reg_en), .core_en(core_en),
    .ref_mode(ref_mode), .converter_bit_clock(bit_clk),
    .sample_clk(sample_clk), .core_usable(core_usable),
    .cal_trim(cal_trim), .ready(ready)
  );

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // --------------------
  // shared tasks
  // --------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // request held until pready is sampled high at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err_seen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask

  task automatic state_is(input logic [4:0] s);
    xfer(1'b0, cps_pkg::STAT_OFS, 32'h0);
    chk({27'h0, q[5:1]}, {27'h0, s});
    chk({31'h0, q[0]}, {31'h0, s[4]});
  endtask

  // bounded so a stuck calibration ends in the report, not a hang
  task automatic wait_ready();
    n = 0;
    while (ready !== 1'b1 && n < 200) begin
      @(posedge pclk);
      #1;
      n++;
    end
  endtask

  // pclk cycles for which sample_clk keeps level v, bounded
  task automatic level_len(input logic v);
    n = 0;
    while (sample_clk === v && n < 1000) begin
      step(1);
      n++;
    end
  endtask

  // track 4+6 and hold 17+3 bit clocks, each 2^(dv+1) or 1 pclk
  task automatic rates(input logic [3:0] dv);
    int f;
    f = (dv <= 4'h3) ? (2 << dv) : 1;
    wr(cps_pkg::CLKS_OFS, {28'h0, dv});
    level_len(1'b1);
    level_len(1'b0);
    level_len(1'b1);
    chk(n, 10 * f);
    level_len(1'b0);
    chk(n, 20 * f);
  endtask

  task automatic results();
    if (mismatches == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // --------------------
  // scenarios
  // --------------------
  task automatic walk_up();
    chk({31'h0, bias_reg_en}, 32'h0);
    chk({24'h0, cal_trim}, 32'h0);
    xfer(1'b0, cps_pkg::CTRL_OFS, 32'h0);
    chk(q, 32'h0);
    state_is(cps_pkg::ST_RESET);
    wr(cps_pkg::CTRL_OFS, 32'h00);
    wr(cps_pkg::CLKS_OFS, 32'h1);
    // for 1.5 us sample periods: 512 bias and 20 wake cycles
    wr(cps_pkg::CNTS_OFS, 32'h87);
    wr(cps_pkg::CTRL_OFS, 32'h01);
    step(2);
    state_is(cps_pkg::ST_SLEEP);
    chk({31'h0, bias_reg_en}, 32'h0);
    wr(cps_pkg::CTRL_OFS, 32'h03);
    step(2);
    state_is(cps_pkg::ST_NAP);
    chk({30'h0, bias_reg_en, core_en}, 32'h2);
    wr(cps_pkg::SAMP_OFS, 32'h0306);
    rates(4'h1);
    rates(4'h4);
    step(WARM);
  endtask

  task automatic cal_entry();
    wr(cps_pkg::SAMP_OFS, 32'h0306);
    wr(cps_pkg::TRIM_OFS, 32'h5a);
    wr(cps_pkg::CNTS_OFS, 32'h87);
    wr(cps_pkg::FLAG_OFS, 32'hffffffff);
    wr(cps_pkg::CTRL_OFS, 32'h07);
    step(1);
    chk({31'h0, core_en}, 32'h1);
    wait_ready();
    chk(32'(n >= CAL && n <= CAL + 2), 32'h1);
    // wake count restarted on leaving nap, so not yet usable
    chk({31'h0, core_usable}, 32'h0);
    n = 0;
    while (core_usable !== 1'b1 && n < 20000) begin
      step(1);
      n++;
    end
    chk({31'h0, core_usable}, 32'h1);
    chk({24'h0, cal_trim}, 32'h5a);
    xfer(1'b0, cps_pkg::CALV_OFS, 32'h0);
    chk(q, 32'h5a);
    xfer(1'b0, cps_pkg::FLAG_OFS, 32'h0);
    chk(q, 32'h1);
    state_is(cps_pkg::ST_ON);
    wr(cps_pkg::FLAG_OFS, 32'hffffffff);
    xfer(1'b0, cps_pkg::FLAG_OFS, 32'h0);
    chk(q, 32'h0);
    chk({31'h0, ready}, 32'h1);
  endtask

  task automatic fall_back();
    wr(cps_pkg::CTRL_OFS, 32'h03);
    step(2);
    state_is(cps_pkg::ST_NAP);
    chk({24'h0, cal_trim}, 32'h5a);
    // trim loaded now must stay pending on the skip path
    wr(cps_pkg::TRIM_OFS, 32'h33);
    wr(cps_pkg::SAMP_OFS, 32'h0306);
    wr(cps_pkg::FLAG_OFS, 32'hffffffff);
    wr(cps_pkg::CTRL_OFS, 32'h0f);
    step(2);
    chk({31'h0, ready}, 32'h1);
    chk({24'h0, cal_trim}, 32'h5a);
    wr(cps_pkg::CTRL_OFS, 32'h01);
    step(2);
    state_is(cps_pkg::ST_SLEEP);
    chk({23'h0, bias_reg_en, cal_trim}, 32'h5a);
    wr(cps_pkg::CTRL_OFS, 32'h00);
    step(2);
    state_is(cps_pkg::ST_RESET);
    chk({24'h0, cal_trim}, 32'h0);
  endtask

  task automatic ref_modes();
    for (int i = 0; i < 4; i++) begin
      wr(cps_pkg::CTRL_OFS, 32'(i << 4));
      step(1);
      chk({30'h0, ref_mode}, (i % 2) ? 32'h2 : 32'(i / 2));
    end
  endtask

  task automatic bad_and_clear();
    xfer(1'b0, 8'h20, 32'h0);
    chk({31'h0, err_seen}, 32'h1);
    chk(q, 32'h0);
    wr(cps_pkg::CTRL_OFS, 32'h03);
    wr(cps_pkg::TRIM_OFS, 32'h77);
    wr(cps_pkg::CTRL_OFS, 32'h07);
    wait_ready();
    chk({24'h0, cal_trim}, 32'h77);
    @(posedge pclk);
    periph_rst <= 1'b1;
    @(posedge pclk);
    periph_rst <= 1'b0;
    step(1);
    chk({22'h0, ready, bias_reg_en, cal_trim}, 32'h0);
    xfer(1'b0, cps_pkg::CTRL_OFS, 32'h0);
    chk(q, 32'h0);
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 50000) begin
      mismatches++;
      results();
    end
  end

  initial begin
    presetn    = 1'b0;
    periph_rst = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    walk_up();
    cal_entry();
    fall_back();
    ref_modes();
    bad_and_clear();
    results();
  end
endmodule
`default_nettype wire
